// >>> src/line_buf.sv
// Behaviour
// - 910 bytes with separate write/read counters
// - Write and read ports run independently
// - Write clear with gate low: address zero
// - Write clear with gate high: address 909
// - Write clear sampled on write clock rise
// - Read clear with gate low: address zero
// - Read clear with gate high: address 909
// - Gate low writes and advances; high holds
// - Read gate high: outputs float, address holds
// - Controls at cycle start, data at end
// - Write address increments, wraps 909 to 0
// - Read clock rise starts the word read
// - Read address increments, wraps 909 to 0
// - Delay line length from 10 to 910
// - Words stay valid at least 1 ms
`timescale 1ns/100ps

module line_buf_stage_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];  // Word storage, no reset needed
  logic [PW-1:0]    wp_q, wp_d;     // Fill pointer
  logic [PW-1:0]    rp_q, rp_d;     // Drain pointer
  logic [PW:0]      cnt_q, cnt_d;   // Occupancy, one bit wider
  logic             push;
  logic             pop;

  // Honest full and empty straight from the count
  assign o_in_ready  = (cnt_q != DEPTH[PW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = store[rp_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Pointer and count next values
  always_comb
  begin
    wp_d  = push ? wp_q + 1'b1 : wp_q;
    rp_d  = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q;
    if (push & ~pop)
    begin
      cnt_d = cnt_q + 1'b1;
    end
    else if (pop & ~push)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage write
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
    begin
      store[wp_q] <= i_in_data;
    end
  end
endmodule

module line_buf (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_srst,
  input  wire logic                       i_wr_clock,
  input  wire logic                       i_wr_addr_clear_n,
  input  wire logic                       i_wr_gate_n,
  input  wire logic [line_buf_pkg::DATA_W-1:0] i_wr_data,
  input  wire logic                       i_rd_clock,
  input  wire logic                       i_rd_addr_clear_n,
  input  wire logic                       i_rd_gate_n,
  output logic [line_buf_pkg::DATA_W-1:0] o_rd_data_out,
  output logic                            o_rd_data_oe,
  output logic                            o_wr_stage_ready
);
  import line_buf_pkg::*;

  // Address step with wrap at the end of the line
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a
  );
    next_addr = (a == ADDR_LAST) ? ADDR_FIRST : a + 1'b1;
  endfunction

  // Preset value chosen by the gate during a clear cycle
  function automatic logic [ADDR_W-1:0] clear_addr(input logic gate_n);
    clear_addr = gate_n ? ADDR_LAST : ADDR_FIRST;
  endfunction

  logic [DATA_W-1:0] line_mem [LINE_WORDS];  // Line storage

  logic [PIN_W-1:0]  pins;            // Raw pin bundle
  logic [PIN_W-1:0]  s1_q, s2_q, s3_q;  // Three-stage chain
  logic [PIN_W-1:0]  lvl_q, lvl_d;    // Agreed pin levels
  logic              wr_rise;         // Write clock edge seen
  logic              rd_rise;         // Read clock edge seen
  logic              wr_clr_n;
  logic              wr_gate;
  logic [DATA_W-1:0] wr_byte;
  logic              rd_clr_n;
  logic              rd_gate;

  logic [ADDR_W-1:0] wa_q, wa_d;       // Write address counter
  logic              pend_q, pend_d;   // Write cycle open
  logic [ADDR_W-1:0] pa_q, pa_d;       // Address of open write cycle
  logic [ADDR_W-1:0] ra_q, ra_d;       // Read address counter
  logic [DATA_W-1:0] rdat_q, rdat_d;   // Output data register
  logic              oe_q, oe_d;       // Output drive enable

  logic              st_valid;
  logic [STAGE_W-1:0] st_data;
  logic              st_ready;
  logic              push_valid;
  logic [STAGE_W-1:0] push_data;

  // Bundle every pin; all come from outside this clock
  assign pins = {i_wr_clock, i_wr_addr_clear_n, i_wr_gate_n, i_wr_data,
                 i_rd_clock, i_rd_addr_clear_n, i_rd_gate_n};

  // Level counts once stages two and three agree
  always_comb
  begin
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  end

  // Synchroniser and agreed levels
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Edges and control levels seen together, so they stay aligned
  assign wr_rise  = lvl_d[13] & ~lvl_q[13];
  assign wr_clr_n = lvl_d[12];
  assign wr_gate  = ~lvl_d[11];
  assign wr_byte  = lvl_d[10:3];
  assign rd_rise  = lvl_d[2] & ~lvl_q[2];
  assign rd_clr_n = lvl_d[1];
  assign rd_gate  = ~lvl_d[0];

  // Closing edge of an open write cycle pushes address and byte
  assign push_valid = wr_rise & pend_q;
  assign push_data  = {pa_q, wr_byte};

  // Write port next state; runs off its own edge only
  always_comb
  begin
    wa_d   = wa_q;
    pend_d = pend_q;
    pa_d   = pa_q;
    if (wr_rise)
    begin
      pend_d = 1'b0;
      if (!wr_clr_n)
      begin
        // Clear cycle presets and opens no write cycle of its own
        wa_d = clear_addr(~wr_gate);
      end
      else if (wr_gate)
      begin
        // Open a cycle; the byte arrives on the next edge
        pend_d = 1'b1;
        pa_d   = wa_q;
        wa_d   = next_addr(wa_q);
      end
      // Gate high: address held, no new write cycle opened
    end
  end

  // Write port registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      wa_q   <= ADDR_FIRST;
      pend_q <= 1'b0;
      pa_q   <= ADDR_FIRST;
    end
    else
    begin
      wa_q   <= wa_d;
      pend_q <= pend_d;
      pa_q   <= pa_d;
    end
  end

  // Staging buffer decouples write edges from the storage port
  line_buf_stage_fifo #(
    .WIDTH (STAGE_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .i_sys_clk   (i_sys_clk),
    .i_srst      (i_srst),
    .i_in_valid  (push_valid),
    .o_in_ready  (o_wr_stage_ready),
    .i_in_data   (push_data),
    .o_out_valid (st_valid),
    .i_out_ready (st_ready),
    .o_out_data  (st_data)
  );

  // Storage is single ported; a read edge takes priority and stalls
  assign st_ready = ~rd_rise;

  // Storage write from the buffer; flops hold words indefinitely
  always_ff @(posedge i_sys_clk)
  begin
    if (st_valid & st_ready)
    begin
      line_mem[st_data[STAGE_W-1:DATA_W]] <= st_data[DATA_W-1:0];
    end
  end

  // Read port next state; runs off its own edge only
  always_comb
  begin
    ra_d   = ra_q;
    rdat_d = rdat_q;
    oe_d   = oe_q;
    if (rd_rise)
    begin
      if (!rd_clr_n)
      begin
        // Clear cycle presets, output follows the gate
        ra_d = clear_addr(~rd_gate);
        oe_d = rd_gate;
      end
      else if (rd_gate)
      begin
        // Word fetched on this edge, held until the next read
        rdat_d = line_mem[ra_q];
        oe_d   = 1'b1;
        ra_d   = next_addr(ra_q);
      end
      else
      begin
        // Disabled: float outputs, hold address
        oe_d = 1'b0;
      end
    end
  end

  // Read port registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ra_q   <= ADDR_FIRST;
      rdat_q <= DATA_RST;
      oe_q   <= 1'b0;
    end
    else
    begin
      ra_q   <= ra_d;
      rdat_q <= rdat_d;
      oe_q   <= oe_d;
    end
  end

  // Delay length follows the controller's clear and gate timing
  assign o_rd_data_out = rdat_q;
  assign o_rd_data_oe  = oe_q;
endmodule

// >>> src/line_buf_pkg.sv
package line_buf_pkg;
  // Storage shape
  localparam int unsigned   DATA_W      = 8;
  localparam int unsigned   ADDR_W      = 10;
  localparam int unsigned   LINE_WORDS  = 910;
  localparam logic [9:0]    ADDR_FIRST  = 10'h000;
  localparam logic [9:0]    ADDR_LAST   = 10'h38D;
  // Write staging buffer
  localparam int unsigned   STAGE_DEPTH = 16;
  localparam int unsigned   STAGE_W     = DATA_W + ADDR_W;
  // Pin input synchroniser
  localparam int unsigned   SYNC_STAGES = 3;
  localparam int unsigned   PIN_W       = 14;
  // Retention figure of stored words, in ns, and its cycle count
  localparam int unsigned   CLK_NS      = 8;
  localparam int unsigned   HOLD_NS     = 1000000;
  localparam int unsigned   HOLD_CYC    = HOLD_NS / CLK_NS;
  // Reset values
  localparam logic [7:0]    DATA_RST    = 8'h00;
endpackage

// >>> tb/line_buf_sva.sv
`timescale 1ns/100ps
module line_buf_sva
  import line_buf_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_srst,
  input wire logic              i_wr_clock,
  input wire logic              i_wr_addr_clear_n,
  input wire logic              i_wr_gate_n,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic              i_rd_clock,
  input wire logic              i_rd_addr_clear_n,
  input wire logic              i_rd_gate_n,
  input wire logic [DATA_W-1:0] o_rd_data_out,
  input wire logic              o_rd_data_oe,
  input wire logic              o_wr_stage_ready
);
  logic       rd_prev_q;  // Read pin a cycle ago
  logic [3:0] rd_age_q;   // Cycles since read pin rose
  logic [3:0] rd_age_d;
  // Saturating age, so a late output change is caught
  always_comb
  begin
    rd_age_d = (rd_age_q == 4'hF) ? 4'hF : rd_age_q + 4'h1;
    if (i_rd_clock && !rd_prev_q)
    begin
      rd_age_d = 4'h0;
    end
  end
  // Low in reset: a pin high at release counts as a rise
  always_ff @(posedge i_sys_clk)
  begin
    rd_prev_q <= i_srst ? 1'b0 : i_rd_clock;
    rd_age_q  <= i_srst ? 4'hF : rd_age_d;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_rise; $rose(i_rd_clock); endsequence
  sequence s_keep; $stable(o_rd_data_out) [*8]; endsequence
  property p_rst; disable iff (1'b0) i_srst |=> !o_rd_data_oe
    && o_rd_data_out == DATA_RST && o_wr_stage_ready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_on; s_rise ##0 !i_rd_gate_n |-> ##[2:7] o_rd_data_oe; endproperty
  a_on: assert property (p_on) else $error("no drive");
  property p_off; s_rise ##0 i_rd_gate_n |-> ##[2:7] !o_rd_data_oe; endproperty
  a_off: assert property (p_off) else $error("still driving");
  property p_clr; s_rise ##0 !i_rd_addr_clear_n |=> s_keep; endproperty
  a_clr: assert property (p_clr) else $error("clear moved data");
  property p_hold; s_rise ##0 i_rd_gate_n |=> s_keep; endproperty
  a_hold: assert property (p_hold) else $error("gated data moved");
  property p_quiet; rd_age_q > 4'h8 |-> $stable(o_rd_data_out)
    && $stable(o_rd_data_oe); endproperty
  a_quiet: assert property (p_quiet) else $error("output moved");
  property p_chg; !$stable(o_rd_data_out) |-> o_rd_data_oe; endproperty
  a_chg: assert property (p_chg) else $error("data while off");
  property p_oe_up; $rose(o_rd_data_oe) |-> rd_age_q <= 4'h7; endproperty
  a_oe_up: assert property (p_oe_up) else $error("late drive");
  property p_oe_dn; $fell(o_rd_data_oe) |-> rd_age_q <= 4'h7; endproperty
  a_oe_dn: assert property (p_oe_dn) else $error("late float");
endmodule

bind line_buf line_buf_sva sva (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
  .i_wr_clock(i_wr_clock), .i_wr_addr_clear_n(i_wr_addr_clear_n),
  .i_wr_gate_n(i_wr_gate_n), .i_wr_data(i_wr_data),
  .i_rd_clock(i_rd_clock), .i_rd_addr_clear_n(i_rd_addr_clear_n),
  .i_rd_gate_n(i_rd_gate_n), .o_rd_data_out(o_rd_data_out),
  .o_rd_data_oe(o_rd_data_oe), .o_wr_stage_ready(o_wr_stage_ready));

// >>> tb/line_ctrl_model.sv
`timescale 1ns/100ps
module line_ctrl_model
  import line_buf_pkg::*;
(
  input  wire logic        i_sys_clk,
  output logic             o_wr_clock,
  output logic             o_wr_addr_clear_n,
  output logic             o_wr_gate_n,
  output logic [DATA_W-1:0] o_wr_data,
  output logic             o_rd_clock,
  output logic             o_rd_addr_clear_n,
  output logic             o_rd_gate_n
);
  // Pin clocks stand low between cycles
  initial
  begin
    {o_wr_clock, o_rd_clock} = 2'b00;
    {o_wr_addr_clear_n, o_wr_gate_n, o_wr_data} = 10'h3FF;
    {o_rd_addr_clear_n, o_rd_gate_n} = 2'b11;
  end
  // Five clocks each side of the rise cover the pin synchroniser
  // A full line pass takes about 80 us, well inside 1 ms
  task automatic wr(input logic c, input logic g, input logic [7:0] d);
    @(posedge i_sys_clk);
    {o_wr_addr_clear_n, o_wr_gate_n, o_wr_data} <= {c, g, d};
    repeat (5) @(posedge i_sys_clk);
    o_wr_clock <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    o_wr_clock <= 1'b0;
  endtask
  // Read cycle, same spacing
  task automatic rd(input logic c, input logic g);
    @(posedge i_sys_clk) {o_rd_addr_clear_n, o_rd_gate_n} <= {c, g};
    repeat (5) @(posedge i_sys_clk);
    o_rd_clock <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    o_rd_clock <= 1'b0;
  endtask
endmodule

// >>> tb/line_buf_tb.sv
`timescale 1ns/100ps
module line_buf_tb;
  import line_buf_pkg::*;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              wr_clock, wclr_n, wg_n, rd_clock, rclr_n, rg_n, oe, rdy;
  logic [DATA_W-1:0] wd, rdo, edat;
  logic [DATA_W-1:0] mem_m [LINE_WORDS];  // Expected line contents
  logic [ADDR_W-1:0] wa, ra, pa;          // Expected addresses
  logic              pend, eoe;           // Open write, expected drive
  logic [31:0]       seed = 32'h0EFE;
  logic [31:0]       s;
  int                error_cnt = 0;
  int                checks_done = 0;

  initial
    forever #4 sys_clk = ~sys_clk;

  line_ctrl_model m (.i_sys_clk(sys_clk), .o_wr_clock(wr_clock),
    .o_wr_addr_clear_n(wclr_n), .o_wr_gate_n(wg_n), .o_wr_data(wd),
    .o_rd_clock(rd_clock), .o_rd_addr_clear_n(rclr_n), .o_rd_gate_n(rg_n));
  line_buf dut (.i_sys_clk(sys_clk), .i_srst(srst), .i_wr_clock(wr_clock),
    .i_wr_addr_clear_n(wclr_n), .i_wr_gate_n(wg_n), .i_wr_data(wd),
    .i_rd_clock(rd_clock), .i_rd_addr_clear_n(rclr_n), .i_rd_gate_n(rg_n),
    .o_rd_data_out(rdo), .o_rd_data_oe(oe), .o_wr_stage_ready(rdy));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Line address after a, wrapping at the last word
  function automatic logic [ADDR_W-1:0] nxt(input logic [ADDR_W-1:0] a);
    return (a == ADDR_LAST) ? ADDR_FIRST : a + 10'h001;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Byte closes the previously opened cycle
  task automatic w(input logic c, input logic g);
    logic [DATA_W-1:0] d;
    d = DATA_W'(xs());
    if (pend)
      mem_m[pa] = d;
    pend = 1'b0;
    if (!c)
      wa = g ? ADDR_LAST : ADDR_FIRST;
    else if (!g)
    begin
      pend = 1'b1;
      pa = wa;
      wa = nxt(wa);
    end
    m.wr(c, g, d);
  endtask
  task automatic r(input logic c, input logic g);
    if (!c)
    begin
      ra = g ? ADDR_LAST : ADDR_FIRST;
      eoe = ~g;
    end
    else if (!g)
    begin
      edat = mem_m[ra];
      eoe = 1'b1;
      ra = nxt(ra);
    end
    else
      eoe = 1'b0;
    m.rd(c, g);
    @(negedge sys_clk);
    chk({7'h00, oe}, {7'h00, eoe});
    chk(rdo, edat);
  endtask

  initial
  begin
    {pend, wa, ra, eoe, edat} = '0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({6'h00, oe, rdy}, 8'h01);
    w(0, 0);
    r(0, 0);
    repeat (912) w(1, 0);
    w(1, 1);
    repeat (912) r(1, 0);
    $display("line pass done");
    w(0, 1);
    w(1, 0);
    w(1, 0);
    w(1, 1);
    r(0, 1);
    r(1, 0);
    r(1, 0);
    $display("preset done");
    // Delay line: write runs ten words ahead of read
    w(0, 0);
    r(0, 0);
    repeat (10) w(1, 0);
    repeat (20)
    begin
      w(1, 0);
      r(1, 0);
    end
    $display("delay line done");
    repeat (400)
    begin
      s = xs();
      if (s[0])
        w(s[1] | s[2] | s[3], s[4]);
      else
        r(s[5] | s[6] | s[7], s[8]);
    end
    $display("random done");
    results;
  end
  // Run should end near 25000 cycles
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    results;
  end
endmodule
